// File: dv/test_watchdog_control_guard.sv
// Self-checking testbench for the watchdog control guard over its AXI4-Lite register bus.
`timescale 1ns/1ps
module test_watchdog_control_guard
  import wdcg_pkg::*;
;
  // ----------------------------------------------------------------
  // Clock, reset, oscillator and design
  // ----------------------------------------------------------------
  logic          clk;
  logic          reset_n;
  logic          wdOscClk;
  logic          chipResetPulse;
  logic          irq;
  wdcg_axi_req_s req;
  wdcg_axi_rsp_s rsp;
  int            fails;
  int            compares;
  int            cycles;
  int            oscDiv;
  logic [31:0]   ticks;
  logic [31:0]   pulses;
  logic [31:0]   rdVal;
  logic [31:0]   t0;
  logic [1:0]    rs;

  // A short base count keeps the longest period near thirteen thousand clocks.
  wdcg_top #(.BASE_CYCLES(4)) wdcg_top_inst (
    .clk            (clk),
    .reset_n        (reset_n),
    .axiReq         (req),
    .axiRsp         (rsp),
    .wdOscClk       (wdOscClk),
    .chipResetPulse (chipResetPulse),
    .irq            (irq)
  );

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    wdOscClk = 1'b0;
    req = '0;
    fails = 0;
    compares = 0;
    cycles = 0;
    oscDiv = 0;
    ticks = '0;
    pulses = '0;
  end

  always #20 clk = ~clk;

  // The oscillator is 25 clocks long, which is one megahertz beside the 25 MHz clock.
  always @(posedge clk)
  begin
    oscDiv <= (oscDiv == 24) ? 0 : oscDiv + 1;
    wdOscClk <= (oscDiv < 12);
  end

  always @(posedge wdOscClk)
    ticks <= ticks + 1;

  always @(posedge clk)
    if (chipResetPulse === 1'b1)
      pulses <= pulses + 1;

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 70000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  // Ready and valid are looked at in the low half, so the next rising edge is the one that takes them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awOk;
    logic wOk;
    logic aR;
    logic wR;
    logic bV;
    awOk = 1'b0;
    wOk = 1'b0;
    bV = 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (bV !== 1'b1)
    begin
      @(negedge clk);
      aR = rsp.awready;
      wR = rsp.wready;
      bV = rsp.bvalid;
      r = rsp.bresp;
      @(posedge clk);
      if (aR === 1'b1 && !awOk)
      begin
        awOk = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (wR === 1'b1 && !wOk)
      begin
        wOk = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic arOk;
    logic aR;
    logic rV;
    arOk = 1'b0;
    rV = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (rV !== 1'b1)
    begin
      @(negedge clk);
      aR = rsp.arready;
      rV = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge clk);
      if (aR === 1'b1 && !arOk)
      begin
        arOk = 1'b1;
        req.arvalid <= 1'b0;
      end
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chkResp(r, RESP_OKAY);
    chkVal(d, exp);
  endtask

  task automatic waitPulse();
    do
      @(negedge clk);
    while (chipResetPulse !== 1'b1);
    @(negedge clk);
    chkVal({31'h0, chipResetPulse}, 32'h0);
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rdChk(8'(i * 4), 32'h0);
    wr(8'h20, 32'hFF, rs);
    chkResp(rs, RESP_SLVERR);
    rd(8'h20, rdVal, rs);
    chkResp(rs, RESP_SLVERR);
    chkVal(rdVal, 32'h0);
    wr(CTRL_OFF, 32'hFF, rs);
    rdChk(CTRL_OFF, 32'h1F);
    rdChk(CTRL_OFF, 32'h1F);
    rdChk(CTRL_OFF, 32'h0F);
    wr(CTRL_OFF, 32'h00, rs);
    rdChk(CTRL_OFF, 32'h08);
    wr(CTRL_OFF, 32'h10, rs);
    rdChk(CTRL_OFF, 32'h18);
    wr(CTRL_OFF, 32'h18, rs);
    wr(CTRL_OFF, 32'h00, rs);
    rdChk(CTRL_OFF, 32'h00);
    t0 = pulses;
    repeat (300) @(posedge clk);
    chkVal(pulses, t0);
    wr(IMASK_OFF, 32'h1, rs);
    wr(CTRL_OFF, 32'h08, rs);
    waitPulse();
    rdChk(CAUSE_OFF, 32'h08);
    wr(CAUSE_OFF, 32'h00, rs);
    rdChk(CAUSE_OFF, 32'h00);
    chkVal({31'h0, irq}, 32'h1);
    rdChk(ISTAT_OFF, 32'h1);
    repeat (2) @(posedge clk);
    chkVal({31'h0, irq}, 32'h0);
    wr(IMASK_OFF, 32'h0, rs);
    waitPulse();
    chkVal({31'h0, irq}, 32'h0);
    rdChk(ISTAT_OFF, 32'h1);
    // Restarts every 40 clocks, under two oscillator ticks, must hold off a four-tick expiry.
    t0 = pulses;
    for (int i = 0; i < 10; i++)
    begin
      wr(RESTART_OFF, 32'h0, rs);
      repeat (40) @(posedge clk);
    end
    chkVal(pulses, t0);
    for (int c = 0; c < 8; c++)
    begin
      wr(CTRL_OFF, 32'h08 | c, rs);
      waitPulse();
      t0 = ticks;
      waitPulse();
      chkVal(ticks - t0, 32'd4 << c);
    end
    tally_and_finish();
  end
endmodule

// File: verilog/wdcg_pkg.sv
// Package for the watchdog control guard: register map, field layout, reset values and bus carriers.
package wdcg_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFF    = 8'h00;
  localparam logic [ADDR_W-1:0] RESTART_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] CAUSE_OFF   = 8'h08;
  localparam logic [ADDR_W-1:0] ISTAT_OFF   = 8'h0C;
  localparam logic [ADDR_W-1:0] IMASK_OFF   = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TOE_BIT    = 4;
  localparam int CTRL_EN_BIT     = 3;
  localparam int CTRL_PER_LSB    = 0;
  localparam int CTRL_RSVD_LSB   = 5;
  localparam int CAUSE_WATCHDOG_RESET_FLAG_BIT  = 3;
  localparam int IRQ_TIMEOUT_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic       EN_RST            = 1'b0;
  localparam logic [2:0] PER_RST           = 3'h0;
  localparam logic       MASK_RST          = 1'b0;
  localparam logic [2:0] TOE_WINDOW_CYCLES = 3'h4;
  localparam int         BASE_OSC_CYCLES   = 16384;
  localparam int         OSC_FREQ_HZ       = 1000000;
  localparam int         CLK_FREQ_HZ       = 25000000;

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } wdcg_axi_req_s;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } wdcg_axi_rsp_s;

  // ----------------------------------------------------------------
  // Top-level state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        oscSync;
    logic              oscPrev;
    logic              awHave;
    logic [ADDR_W-1:0] awAddr;
    logic              wHave;
    logic [DATA_W-1:0] wData;
    logic [3:0]        wStrb;
    logic              toe;
    logic [2:0]        toeCnt;
    logic              enable;
    logic [2:0]        period;
    logic              resetFlag;
    logic              irqStat;
    logic              irqMask;
    logic              restart;
    logic              chipReset;
    logic              irq;
    wdcg_axi_rsp_s     rsp;
  } wdcg_state_s;

endpackage

// File: verilog/wdcg_timeout_counter.sv
// Watchdog time-out counter advanced by oscillator ticks.
`timescale 1ns/1ps
module wdcg_timeout_counter
  import wdcg_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_OSC_CYCLES
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       oscTick,
  input  wire logic       restart,
  input  wire logic       enable,
  input  wire logic [2:0] periodSel,
  // Result
  output logic            expired
);

  localparam int CNT_W = $clog2(BASE_CYCLES) + 8;

  if (BASE_CYCLES < 2)
  begin : g_chk
    $error("BASE_CYCLES must be at least 2");
  end

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] limit;
  logic             hit;

  // Each code step doubles the period.
  assign limit = CNT_W'(BASE_CYCLES) << periodSel;
  assign hit   = enable && oscTick && (count_q == limit - CNT_W'(1));
  assign expired = hit && !restart;

  always_comb
  begin
    count_d = count_q;
    if (restart || !enable)
      count_d = '0;
    else if (hit)
      count_d = '0;
    else if (oscTick)
      count_d = count_q + CNT_W'(1);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  property p_restart_clears;
    @(posedge clk) disable iff (!reset_n) (restart || !enable) |=> count_q == '0;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("counter not cleared");

  property p_tick_counts;
    @(posedge clk) disable iff (!reset_n)
      (enable && oscTick && !restart && !hit) |=> count_q == $past(count_q) + CNT_W'(1);
  endproperty
  a_tick_counts: assert property (p_tick_counts) else $error("tick did not advance");

  property p_expire_at_limit;
    @(posedge clk) disable iff (!reset_n)
      expired |-> enable && count_q == (CNT_W'(BASE_CYCLES) << periodSel) - CNT_W'(1);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit) else $error("expiry off limit");

endmodule

// File: verilog/wdcg_top.sv
// Watchdog control guard: AXI4-Lite register file, timed turn-off sequence and time-out reset.
`timescale 1ns/1ps

// Summary of operation
// - Control bits 7:5 are reserved and always read as zero.
// - A write clearing enable is ignored unless turn-off-enable is already set.
// - Turn-off-enable clears itself four clock cycles after being written one.
// - Writing one to enable turns the watchdog on; zero turns it off when permitted.
// - Enable may fall from one to zero only while turn-off-enable reads one.
// - Period select chooses 16384 times two-to-the-code oscillator cycles.
// - The counter advances on a separate one megahertz oscillator.
// - Counter restarts on restart command, when disabled, and on chip reset.
// - Expiry while enabled produces a one-cycle chip reset pulse.
// - Each watchdog reset sets the watchdog reset flag.
module wdcg_top
  import wdcg_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_OSC_CYCLES
)(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Register bus
  input  wire wdcg_axi_req_s axiReq,
  output wdcg_axi_rsp_s      axiRsp,
  // Watchdog oscillator pin
  input  wire logic          wdOscClk,
  // Outputs to the chip
  output logic               chipResetPulse,
  output logic               irq
);

  // ----------------------------------------------------------------
  // Checks and decode helpers
  // ----------------------------------------------------------------
  // The oscillator pin is sampled, so it must be well below half the clock rate.
  if (OSC_FREQ_HZ * 4 > CLK_FREQ_HZ)
  begin : g_chk
    $error("Watchdog oscillator too fast for edge sampling");
  end

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == CTRL_OFF) || (a == RESTART_OFF) || (a == CAUSE_OFF) ||
               (a == ISTAT_OFF) || (a == IMASK_OFF);
  endfunction

  wdcg_state_s st_q;
  wdcg_state_s st_d;
  logic        oscTick;
  logic        expired;
  logic        doWrite;
  logic        ctrlWrite;
  logic        doRead;
  logic [7:0]  ctrlView;
  logic        wrToe;
  logic        wrEn;

  assign oscTick   = st_q.oscSync[1] && !st_q.oscPrev;
  assign doWrite   = st_q.awHave && st_q.wHave && !st_q.rsp.bvalid;
  assign ctrlWrite = doWrite && (st_q.awAddr == CTRL_OFF) && st_q.wStrb[0];
  assign doRead    = axiReq.arvalid && st_q.rsp.arready;
  assign wrToe     = st_q.wData[CTRL_TOE_BIT];
  assign wrEn      = st_q.wData[CTRL_EN_BIT];
  assign ctrlView  = {3'h0, st_q.toe, st_q.enable, st_q.period};

  // ----------------------------------------------------------------
  // Time-out counter
  // ----------------------------------------------------------------
  wdcg_timeout_counter #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_counter (
    .clk       (clk),
    .reset_n   (reset_n),
    .oscTick   (oscTick),
    .restart   (st_q.restart),
    .enable    (st_q.enable),
    .periodSel (st_q.period),
    .expired   (expired)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    // Oscillator pin passes two flops before the edge detector reads it.
    st_d.oscSync = {st_q.oscSync[0], wdOscClk};
    st_d.oscPrev = st_q.oscSync[1];
    st_d.restart = 1'b0;
    st_d.chipReset = 1'b0;

    // Address and data are taken independently, in either order.
    if (axiReq.awvalid && st_q.rsp.awready)
    begin
      st_d.awHave = 1'b1;
      st_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_q.rsp.wready)
    begin
      st_d.wHave = 1'b1;
      st_d.wData = axiReq.wdata;
      st_d.wStrb = axiReq.wstrb;
    end
    if (st_q.rsp.bvalid && axiReq.bready)
      st_d.rsp.bvalid = 1'b0;

    // Turn-off-enable window, counted in system clocks.
    if (st_q.toe)
    begin
      if (st_q.toeCnt == 3'h0)
        st_d.toe = 1'b0;
      else
        st_d.toeCnt = st_q.toeCnt - 3'h1;
    end

    if (doWrite)
    begin
      st_d.awHave = 1'b0;
      st_d.wHave = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      st_d.rsp.bresp = isMapped(st_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (ctrlWrite)
      begin
        st_d.period = st_q.wData[CTRL_PER_LSB +: 3];
        if (wrEn)
          st_d.enable = 1'b1;
        else if (st_q.toe)
          st_d.enable = 1'b0;
        if (wrToe)
        begin
          st_d.toe = 1'b1;
          st_d.toeCnt = TOE_WINDOW_CYCLES - 3'h1;
        end
      end
      if (st_q.awAddr == RESTART_OFF)
        st_d.restart = 1'b1;
      if ((st_q.awAddr == CAUSE_OFF) && st_q.wStrb[0] && !st_q.wData[CAUSE_WATCHDOG_RESET_FLAG_BIT])
        st_d.resetFlag = 1'b0;
      if ((st_q.awAddr == IMASK_OFF) && st_q.wStrb[0])
        st_d.irqMask = st_q.wData[IRQ_TIMEOUT_BIT];
    end

    // Reads answer one cycle after acceptance; status clears on read.
    if (st_q.rsp.rvalid && axiReq.rready)
      st_d.rsp.rvalid = 1'b0;
    if (doRead)
    begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rresp = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      st_d.rsp.rdata = '0;
      case (axiReq.araddr)
        CTRL_OFF:  st_d.rsp.rdata[7:0] = ctrlView;
        CAUSE_OFF: st_d.rsp.rdata[CAUSE_WATCHDOG_RESET_FLAG_BIT] = st_q.resetFlag;
        ISTAT_OFF:
        begin
          st_d.rsp.rdata[IRQ_TIMEOUT_BIT] = st_q.irqStat;
          st_d.irqStat = 1'b0;
        end
        IMASK_OFF: st_d.rsp.rdata[IRQ_TIMEOUT_BIT] = st_q.irqMask;
        default:   st_d.rsp.rdata = '0;
      endcase
    end

    // Expiry events win over any clear in the same cycle.
    if (expired)
    begin
      st_d.chipReset = 1'b1;
      st_d.resetFlag = 1'b1;
      st_d.irqStat = 1'b1;
    end

    st_d.irq = st_d.irqStat && st_d.irqMask;
    st_d.rsp.awready = !st_d.awHave && !st_d.rsp.bvalid;
    st_d.rsp.wready = !st_d.wHave && !st_d.rsp.bvalid;
    st_d.rsp.arready = !st_d.rsp.rvalid;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      st_q.enable <= EN_RST;
      st_q.period <= PER_RST;
      st_q.irqMask <= MASK_RST;
    end
    else
      st_q <= st_d;
  end

  assign axiRsp = st_q.rsp;
  assign chipResetPulse = st_q.chipReset;
  assign irq = st_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rsvd_zero;
    @(posedge clk) disable iff (!reset_n)
      (doRead && axiReq.araddr == CTRL_OFF) |=> axiRsp.rvalid && axiRsp.rdata[7:5] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_guarded_clear;
    @(posedge clk) disable iff (!reset_n)
      (ctrlWrite && !wrEn && !st_q.toe && st_q.enable) |=> st_q.enable;
  endproperty
  a_guarded_clear: assert property (p_guarded_clear) else $error("enable cleared without guard");

  property p_toe_window;
    @(posedge clk) disable iff (!reset_n)
      (ctrlWrite && wrToe) ##1 (!(ctrlWrite && wrToe)) [*4] |-> (st_q.toe && $past(st_q.toe, 3)) ##1 !st_q.toe;
  endproperty
  a_toe_window: assert property (p_toe_window) else $error("turn-off window not four cycles");

  property p_enable_set;
    @(posedge clk) disable iff (!reset_n) (ctrlWrite && wrEn) |=> st_q.enable;
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enable not set");

  property p_fall_needs_toe;
    @(posedge clk) disable iff (!reset_n) $fell(st_q.enable) |-> $past(st_q.toe);
  endproperty
  a_fall_needs_toe: assert property (p_fall_needs_toe) else $error("enable fell without guard");

  property p_window_start;
    @(posedge clk) disable iff (!reset_n)
      (ctrlWrite && wrToe) |=> st_q.toe && st_q.toeCnt == TOE_WINDOW_CYCLES - 3'h1;
  endproperty
  a_window_start: assert property (p_window_start) else $error("window start wrong");

  property p_reset_pulse;
    @(posedge clk) disable iff (!reset_n) expired |=> chipResetPulse ##1 !chipResetPulse;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse not one cycle");

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n) chipResetPulse |-> st_q.resetFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("watchdog flag not set");

  property p_restart_cmd;
    @(posedge clk) disable iff (!reset_n)
      (doWrite && st_q.awAddr == RESTART_OFF) |=> st_q.restart ##1 !st_q.restart;
  endproperty
  a_restart_cmd: assert property (p_restart_cmd) else $error("restart not issued");

  property p_no_expire_off;
    @(posedge clk) disable iff (!reset_n) expired |-> st_q.enable;
  endproperty
  a_no_expire_off: assert property (p_no_expire_off) else $error("expiry while disabled");

  // ----------------------------------------------------------------
  // Register side-effect checks
  // ----------------------------------------------------------------
  // These pin rises of turn-off-enable and enable, period changes, the watchdog flag, restart and the reset pulse to the cause allowed to make them.
  property p_toe_by_write;
    @(posedge clk) disable iff (!reset_n) $rose(st_q.toe) |-> $past(ctrlWrite && wrToe);
  endproperty
  a_toe_by_write: assert property (p_toe_by_write) else $error("turn-off enable rose without write");

  property p_enable_by_write;
    @(posedge clk) disable iff (!reset_n) $rose(st_q.enable) |-> $past(ctrlWrite && wrEn);
  endproperty
  a_enable_by_write: assert property (p_enable_by_write) else $error("enable rose without write");

  property p_period_write;
    @(posedge clk) disable iff (!reset_n)
      ctrlWrite |=> st_q.period == $past(st_q.wData[CTRL_PER_LSB +: 3]);
  endproperty
  a_period_write: assert property (p_period_write) else $error("period not taken from write");

  property p_period_hold;
    @(posedge clk) disable iff (!reset_n) !ctrlWrite |=> $stable(st_q.period);
  endproperty
  a_period_hold: assert property (p_period_hold) else $error("period changed without write");

  property p_flag_sticky;
    @(posedge clk) disable iff (!reset_n)
      (st_q.resetFlag && !(doWrite && st_q.awAddr == CAUSE_OFF)) |=> st_q.resetFlag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("watchdog flag lost");

  property p_flag_clear;
    @(posedge clk) disable iff (!reset_n)
      (doWrite && st_q.awAddr == CAUSE_OFF && st_q.wStrb[0] && !st_q.wData[CAUSE_WATCHDOG_RESET_FLAG_BIT] && !expired)
        |=> !st_q.resetFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("watchdog flag not cleared");

  property p_restart_only_cmd;
    @(posedge clk) disable iff (!reset_n) st_q.restart |-> $past(doWrite && st_q.awAddr == RESTART_OFF);
  endproperty
  a_restart_only_cmd: assert property (p_restart_only_cmd) else $error("restart without command");

  property p_pulse_needs_expiry;
    @(posedge clk) disable iff (!reset_n) chipResetPulse |-> $past(expired);
  endproperty
  a_pulse_needs_expiry: assert property (p_pulse_needs_expiry) else $error("reset pulse without expiry");

  c_disable: cover property (@(posedge clk) disable iff (!reset_n) $fell(st_q.enable));
  c_timeout: cover property (@(posedge clk) disable iff (!reset_n) chipResetPulse);
  c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
  c_slverr: cover property (@(posedge clk) disable iff (!reset_n) axiRsp.bvalid && axiRsp.bresp == RESP_SLVERR);

endmodule
